/* logic/dasrs_cfg.svh */
// Constants for the accumulator store, round and shift path.
// Assumes inclusion by the package and design files of this block only.
// Summary of operation
// - Only the MAC op may store rounded high word of the other accumulator.
// - Write-back goes over the X bus to any X or Y data address.
// - Register-direct mode puts rounded other accumulator into the write-back pointer.
// - Indirect mode stores at the pointer address, then adds 2 to the pointer.
// - Combinational round picks conventional or convergent by round mode bit.
// - Without rounding, the high word is stored truncated and low word dropped.
// - Conventional round increments high word when low word is 0x8000 or more.
// - Convergent round at exactly 0x8000 increments only when bit 16 is one.
// - Store op writes truncated word, rounded variant rounded, both saturated.
// - Multiply-accumulate write-back is always rounded.
// - Store saturation changes only the written word (memory value or direct-mode pointer), never the accumulator.
// - Saturation stage uses rounded word plus accumulator and round adder overflow.
// - With saturation enabled, values above 0x007fff are written as 0x7fff.
// - With saturation enabled, values below 0xff8000 are written as 0x8000.
// - The operand sign for saturation comes from accumulator bit 39.
// - With saturation disabled, the rounded word is written unchanged.
// - Shifter does arithmetic, logical right or left shifts up to 16 in one cycle.
// - Shifter operand is either accumulator or the X data bus.
// - Signed amount: positive shifts right, negative left, zero passes unchanged.
// - Shifter is 40 bits: 40-bit accumulator result, 16-bit general result.
// - X bus operand sits at bits 16 to 31 for right, 0 upward for left.
`ifndef DASRS_CFG_SVH
`define DASRS_CFG_SVH
`define DASRS_ACC_W 40
`define DASRS_WORD_W 16
`define DASRS_HI_LSB 16
`define DASRS_SIGN_BIT 39
`define DASRS_HALF 16'h8000
`define DASRS_POS_MAX 16'h7fff
`define DASRS_NEG_MAX 16'h8000
`define DASRS_PTR_STEP 16'h0002
`define DASRS_MAX_SHIFT 16
`define DASRS_PTR_RESET 16'h0000
`endif

/* logic/dasrs_pkg.sv */
// Types for the accumulator store, round and shift path.
// Assumes the configuration header is on the include path.
`include "dasrs_cfg.svh"
package dasrs_pkg;
	typedef enum logic [1:0] {DASRS_WB_NONE, DASRS_WB_DIRECT, DASRS_WB_INDIRECT} dasrs_wb_mode_type;
	typedef enum logic [2:0] {DASRS_OP_OTHER, DASRS_OP_MAC, DASRS_OP_MPY, DASRS_OP_MPYN,
		DASRS_OP_SQD, DASRS_OP_SQDAC, DASRS_OP_STORE, DASRS_OP_STORE_RND} dasrs_op_type;
	typedef enum logic [1:0] {DASRS_SRC_ACCA, DASRS_SRC_ACCB, DASRS_SRC_XBUS} dasrs_src_type;
	typedef struct packed {
		logic valid;
		dasrs_op_type op;
		logic target_b;
		dasrs_wb_mode_type wb_mode;
	} dasrs_store_req_type;
	typedef struct packed {
		logic valid;
		dasrs_src_type src;
		logic arith;
		logic signed [5:0] amount;
	} dasrs_shift_req_type;
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} dasrs_xwrite_type;
endpackage

/* logic/dasrs_round.sv */
// Combinational round and data write saturation for one accumulator word.
// Assumes a 40-bit accumulator from the same clock domain.
`timescale 1ns/1ps
`include "dasrs_cfg.svh"
module dasrs_round (
	input wire logic [`DASRS_ACC_W-1:0] i_acc,
	input wire logic i_round,
	input wire logic i_round_mode_select,
	input wire logic i_store_saturate_enable,
	output logic [`DASRS_WORD_W-1:0] o_word
);
	logic [15:0] acc_low_word;
	logic [15:0] acc_high_word;
	logic inc;
	logic [16:0] sum;
	logic [24:0] ext;
	logic sign;
	logic pos_ovf;
	logic neg_ovf;
	always_comb begin
		acc_low_word = i_acc[15:0];
		acc_high_word = i_acc[31:16];
		inc = 1'b0;
		if (i_round) begin
			if (acc_low_word == `DASRS_HALF && i_round_mode_select) begin
				inc = i_acc[`DASRS_HI_LSB];
			end else begin
				inc = acc_low_word[15];
			end
		end
		sum = {1'b0, acc_high_word} + {16'h0000, inc};
		ext = {1'b0, 8'(i_acc[39:32] + {7'h00, sum[16]}), sum[15:0]};
		sign = i_acc[`DASRS_SIGN_BIT];
		pos_ovf = !sign && (ext[23:15] != 9'h000);
		neg_ovf = sign && (ext[23:15] != 9'h1ff);
		if (i_store_saturate_enable && pos_ovf) begin
			o_word = `DASRS_POS_MAX;
		end else if (i_store_saturate_enable && neg_ovf) begin
			o_word = `DASRS_NEG_MAX;
		end else begin
			o_word = sum[15:0];
		end
	end
endmodule // dasrs_round

/* logic/dasrs_shift.sv */
// Combinational 40-bit bidirectional barrel shifter.
// Assumes the shift amount lies within plus or minus sixteen.
`timescale 1ns/1ps
`include "dasrs_cfg.svh"
module dasrs_shift (
	input wire logic [`DASRS_ACC_W-1:0] i_acc,
	input wire logic i_from_bus,
	input wire logic [`DASRS_WORD_W-1:0] i_bus,
	input wire logic i_arith,
	input wire logic signed [5:0] i_amount,
	output logic [`DASRS_ACC_W-1:0] o_result
);
	logic [39:0] opnd;
	logic [5:0] mag;
	always_comb begin
		mag = i_amount[5] ? 6'(-i_amount) : 6'(i_amount);
		if (i_from_bus) begin
			if (i_amount[5]) begin
				opnd = {24'h000000, i_bus};
			end else begin
				opnd = {8'h00, i_bus, 16'h0000};
			end
		end else begin
			opnd = i_acc;
		end
		if (i_amount == 6'sh00) begin
			o_result = opnd;
		end else if (i_amount[5]) begin
			o_result = opnd << mag;
		end else if (i_arith && !i_from_bus) begin
			o_result = 40'($signed(opnd) >>> mag);
		end else if (i_arith) begin
			o_result = 40'($signed({{8{i_bus[15]}}, i_bus, 16'h0000}) >>> mag);
		end else begin
			o_result = opnd >> mag;
		end
	end
endmodule // dasrs_shift

/* logic/dasrs_top.sv */
// Store, round and shift path of the 40-bit accumulator datapath.
// Assumes decoder requests and X bus data arrive on the core clock.
`timescale 1ns/1ps
`include "dasrs_cfg.svh"
module dasrs_top (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_round_mode_select,
	input wire logic i_store_saturate_enable,
	input wire logic [`DASRS_ACC_W-1:0] i_acc_a,
	input wire logic [`DASRS_ACC_W-1:0] i_acc_b,
	input wire logic [`DASRS_WORD_W-1:0] i_store_addr,
	input wire logic [`DASRS_WORD_W-1:0] i_xbus_rdata,
	input wire dasrs_pkg::dasrs_store_req_type i_store,
	input wire dasrs_pkg::dasrs_shift_req_type i_shift,
	output dasrs_pkg::dasrs_xwrite_type o_xwrite,
	output logic [`DASRS_WORD_W-1:0] o_writeback_pointer_reg,
	output logic [`DASRS_ACC_W-1:0] o_shift_acc,
	output logic [`DASRS_WORD_W-1:0] o_shift_word,
	output logic o_shift_valid
);
	logic [39:0] src_acc;
	logic do_round;
	logic wb_ok;
	logic [15:0] word;
	logic [39:0] sh_res;
	dasrs_pkg::dasrs_xwrite_type xw_d;
	dasrs_pkg::dasrs_xwrite_type xw_q;
	logic [15:0] ptr_d;
	logic [15:0] ptr_q;
	logic [39:0] sacc_d;
	logic [39:0] sacc_q;
	logic [15:0] sword_d;
	logic [15:0] sword_q;
	logic sval_d;
	logic sval_q;

	always_comb begin
		wb_ok = i_store.op == dasrs_pkg::DASRS_OP_MAC;
		if (wb_ok) begin
			src_acc = i_store.target_b ? i_acc_a : i_acc_b;
			do_round = 1'b1;
		end else begin
			src_acc = i_store.target_b ? i_acc_b : i_acc_a;
			do_round = i_store.op == dasrs_pkg::DASRS_OP_STORE_RND;
		end
	end

	dasrs_round u_round (
		.i_acc(src_acc),
		.i_round(do_round),
		.i_round_mode_select(i_round_mode_select),
		.i_store_saturate_enable(i_store_saturate_enable),
		.o_word(word)
	);

	dasrs_shift u_shift (
		.i_acc(i_shift.src == dasrs_pkg::DASRS_SRC_ACCB ? i_acc_b : i_acc_a),
		.i_from_bus(i_shift.src == dasrs_pkg::DASRS_SRC_XBUS),
		.i_bus(i_xbus_rdata),
		.i_arith(i_shift.arith),
		.i_amount(i_shift.amount),
		.o_result(sh_res)
	);

	always_comb begin
		xw_d = '0;
		ptr_d = ptr_q;
		if (i_store.valid && wb_ok) begin
			if (i_store.wb_mode == dasrs_pkg::DASRS_WB_DIRECT) begin
				ptr_d = word;
			end else if (i_store.wb_mode == dasrs_pkg::DASRS_WB_INDIRECT) begin
				xw_d.valid = 1'b1;
				xw_d.addr = ptr_q;
				xw_d.data = word;
				ptr_d = ptr_q + `DASRS_PTR_STEP;
			end
		end else if (i_store.valid && (i_store.op == dasrs_pkg::DASRS_OP_STORE ||
			i_store.op == dasrs_pkg::DASRS_OP_STORE_RND)) begin
			xw_d.valid = 1'b1;
			xw_d.addr = i_store_addr;
			xw_d.data = word;
		end
		sval_d = i_shift.valid;
		sacc_d = i_shift.valid ? sh_res : sacc_q;
		sword_d = i_shift.valid ? sh_res[31:16] : sword_q;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			xw_q <= '0;
			ptr_q <= `DASRS_PTR_RESET;
			sacc_q <= '0;
			sword_q <= '0;
			sval_q <= 1'b0;
		end else begin
			xw_q <= xw_d;
			ptr_q <= ptr_d;
			sacc_q <= sacc_d;
			sword_q <= sword_d;
			sval_q <= sval_d;
		end
	end

	assign o_xwrite = xw_q;
	assign o_writeback_pointer_reg = ptr_q;
	assign o_shift_acc = sacc_q;
	assign o_shift_word = sword_q;
	assign o_shift_valid = sval_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	ptr_step_a: assert property (i_store.valid && wb_ok &&
		i_store.wb_mode == dasrs_pkg::DASRS_WB_INDIRECT |=> o_writeback_pointer_reg ==
		$past(o_writeback_pointer_reg) + 16'h0002 && o_xwrite.addr ==
		$past(o_writeback_pointer_reg)) else $error("Pointer step wrong.");
	ptr_direct_a: assert property (i_store.valid && wb_ok &&
		i_store.wb_mode == dasrs_pkg::DASRS_WB_DIRECT |=> !o_xwrite.valid &&
		o_writeback_pointer_reg == $past(word)) else $error("Direct write-back wrong.");
	no_wb_a: assert property (i_store.valid && (i_store.op == dasrs_pkg::DASRS_OP_MPY ||
		i_store.op == dasrs_pkg::DASRS_OP_SQD) |=> !o_xwrite.valid)
		else $error("Write-back on excluded op.");
	trunc_a: assert property (i_store.valid && i_store.op == dasrs_pkg::DASRS_OP_STORE &&
		!i_store_saturate_enable |=> o_xwrite.valid &&
		o_xwrite.data == $past(src_acc[31:16])) else $error("Truncated store wrong.");
	round_conv_a: assert property (i_store.valid && wb_ok && !i_store_saturate_enable &&
		!i_round_mode_select |=> o_xwrite.data == 16'($past(src_acc[31:16]) +
		{15'h0000, $past(src_acc[15])}) || !o_xwrite.valid)
		else $error("Conventional round wrong.");
	round_conv2_a: assert property (do_round && i_round_mode_select &&
		src_acc[15:0] == 16'h8000 && !src_acc[16] && !i_store_saturate_enable
		|-> word == src_acc[31:16]) else $error("Convergent round wrong.");
	sat_pos_a: assert property (i_store_saturate_enable && !src_acc[39] &&
		src_acc[38:31] != 8'h00 |-> word == 16'h7fff)
		else $error("Positive saturation missed.");
	sat_neg_a: assert property (i_store_saturate_enable && src_acc[39] &&
		src_acc[38:31] != 8'hff |-> word == 16'h8000)
		else $error("Negative saturation missed.");
	sat_round_a: assert property (i_store_saturate_enable && do_round && !src_acc[39] &&
		src_acc[38:15] == 24'h00ffff |-> word == 16'h7fff)
		else $error("Round carry wrapped.");
	shift_zero_a: assert property (i_shift.valid && i_shift.amount == 6'sh00 &&
		i_shift.src == dasrs_pkg::DASRS_SRC_ACCA |=> o_shift_valid &&
		o_shift_acc == $past(i_acc_a)) else $error("Zero shift changed value.");

	wb_cov: cover property (i_store.valid && wb_ok &&
		i_store.wb_mode == dasrs_pkg::DASRS_WB_INDIRECT);
	sat_cov: cover property (i_store.valid && i_store_saturate_enable && word == 16'h7fff);
	shl_cov: cover property (i_shift.valid && i_shift.amount == -6'sd16);
	shr_cov: cover property (i_shift.valid && i_shift.amount == 6'sd16 && i_shift.arith);
endmodule // dasrs_top

/* bench/dasrs_xmem.sv */
// Data memory model on the X write bus that stores and counts each word write.
// Assumes one write a cycle at most, on the core clock.
`timescale 1ns/1ps
module dasrs_xmem (
	input wire logic i_core_clk,
	input wire dasrs_pkg::dasrs_xwrite_type i_xwrite,
	output logic [31:0] o_count
);
	logic [15:0] mem_q [0:32767];
	initial o_count = 32'h0;
	always @(posedge i_core_clk) begin
		if (i_xwrite.valid === 1'b1) begin
			mem_q[i_xwrite.addr[15:1]] <= i_xwrite.data;
			o_count <= o_count + 32'h1;
		end
	end
endmodule // dasrs_xmem

/* bench/dasrs_bench.sv */
// Self-checking bench for the accumulator store, round and shift path.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/1ps
module dasrs_bench;
	logic clk = 1'b0, rst = 1'b1, cvg = 1'b0, sat = 1'b0;
	logic [39:0] acc_a = 40'h0, acc_b = 40'h0, sh_acc;
	logic [15:0] st_addr = 16'h0, bus = 16'h0, ptr, sh_word;
	dasrs_pkg::dasrs_store_req_type st = '0;
	dasrs_pkg::dasrs_shift_req_type sh = '0;
	dasrs_pkg::dasrs_xwrite_type xw;
	logic sh_v;
	logic [31:0] wr_cnt;
	int err_total = 0, check_count = 0;
	dasrs_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_round_mode_select(cvg),
		.i_store_saturate_enable(sat), .i_acc_a(acc_a), .i_acc_b(acc_b),
		.i_store_addr(st_addr), .i_xbus_rdata(bus), .i_store(st), .i_shift(sh),
		.o_xwrite(xw), .o_writeback_pointer_reg(ptr), .o_shift_acc(sh_acc),
		.o_shift_word(sh_word), .o_shift_valid(sh_v));
	dasrs_xmem u_mem (.i_core_clk(clk), .i_xwrite(xw), .o_count(wr_cnt));
	initial forever #5 clk = ~clk;
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] ew(input logic [39:0] a, input logic r, input logic c,
		input logic s);
		logic [23:0] v;
		v = a[39:16] + {23'h0, r & a[15] & ((a[14:0] != 15'h0) | ~c | a[16])};
		if (s & ~a[39] & (v > 24'h007fff)) return 16'h7fff;
		if (s & a[39] & (v < 24'hff8000)) return 16'h8000;
		return v[15:0];
	endfunction
	function automatic logic [39:0] es(input logic [39:0] a, input logic x, input logic ar,
		input int n);
		logic [39:0] v;
		v = !x ? a : (n >= 0) ? {{8{ar & bus[15] & (n > 0)}}, bus, 16'h0} : {24'h0, bus};
		if (n < 0) return v << -n;
		return ar ? 40'($signed(v) >>> n) : v >> n;
	endfunction
	// Caller waits for a rising edge first; the request stands for that one edge.
	task automatic do_st(input dasrs_pkg::dasrs_op_type op, input logic tb,
		input dasrs_pkg::dasrs_wb_mode_type m, input logic [39:0] va, input logic [39:0] vb);
		st <= '{1'b1, op, tb, m};
		acc_a <= va;
		acc_b <= vb;
		@(posedge clk);
		st.valid <= 1'b0;
		@(negedge clk);
	endtask
	task automatic t_store;
		logic [39:0] ta [11] = '{40'h00_1234_7fff, 40'h00_1234_8000, 40'h00_1234_8000,
			40'h00_1235_8000, 40'h00_1234_ffff, 40'h00_7fff_8000, 40'h00_7fff_8000,
			40'h01_2345_0000, 40'hff_1234_0000, 40'hff_8000_0000, 40'h00_1235_9000};
		logic [2:0] tf [11] = '{3'h4, 3'h4, 3'h6, 3'h6, 3'h0, 3'h5, 3'h4, 3'h1, 3'h1, 3'h7, 3'h7};
		logic [15:0] ad;
		for (int i = 0; i < 11; i++) begin
			ad = 16'hfffe - 16'(2 * i);
			@(posedge clk);
			cvg <= tf[i][1];
			sat <= tf[i][0];
			st_addr <= ad;
			do_st(tf[i][2] ? dasrs_pkg::DASRS_OP_STORE_RND : dasrs_pkg::DASRS_OP_STORE, i[0],
				dasrs_pkg::DASRS_WB_NONE, i[0] ? ~ta[i] : ta[i], i[0] ? ta[i] : ~ta[i]);
			chk("store", {8'h1, ad, ew(ta[i], tf[i][2], tf[i][1], tf[i][0])}, {7'h0, xw});
		end
	endtask
	task automatic t_mac;
		@(posedge clk);
		sat <= 1'b0;
		cvg <= 1'b0;
		do_st(dasrs_pkg::DASRS_OP_MAC, 1'b0, dasrs_pkg::DASRS_WB_DIRECT, 40'h0, 40'h00_0fff_c000);
		chk("direct", 40'h1000, {7'h0, xw.valid, 16'h0, ptr});
		@(posedge clk);
		sat <= 1'b1;
		st <= '{1'b1, dasrs_pkg::DASRS_OP_MAC, 1'b1, dasrs_pkg::DASRS_WB_INDIRECT};
		acc_a <= 40'h00_7fff_8000;
		acc_b <= 40'h0;
		@(posedge clk);
		@(negedge clk);
		chk("indirect1", {8'h1, 16'h1000, 16'h7fff}, {7'h0, xw});
		chk("ptr1", 40'h1002, {24'h0, ptr});
		@(posedge clk);
		st.valid <= 1'b0;
		@(negedge clk);
		chk("indirect2", {8'h1, 16'h1002, 16'h7fff}, {7'h0, xw});
		chk("ptr2", 40'h1004, {24'h0, ptr});
	endtask
	task automatic t_refuse;
		dasrs_pkg::dasrs_op_type ops [6] = '{dasrs_pkg::DASRS_OP_OTHER, dasrs_pkg::DASRS_OP_MPY,
			dasrs_pkg::DASRS_OP_MPYN, dasrs_pkg::DASRS_OP_SQD, dasrs_pkg::DASRS_OP_SQDAC,
			dasrs_pkg::DASRS_OP_MAC};
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			do_st(ops[i], 1'b0, (i == 5) ? dasrs_pkg::DASRS_WB_NONE :
				dasrs_pkg::DASRS_WB_INDIRECT, 40'h0, 40'h00_1111_0000);
			chk("refused", 40'h1004, {23'h0, xw.valid, ptr});
		end
	endtask
	task automatic t_shift;
		logic [39:0] sa [8] = '{40'h80_0000_0001, 40'h80_0000_0001, 40'h00_0000_ffff,
			40'h12_3456_789a, 40'h0, 40'h0, 40'h0, 40'hff_ffff_0000};
		int sn [8] = '{4, 4, -16, 0, 16, 1, -4, 16};
		logic [1:0] sc [8] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h1};
		logic [7:0] sr = 8'b1001_0001;
		logic [39:0] e;
		for (int i = 0; i <= 8; i++) begin
			@(posedge clk);
			if (i < 8) begin
				sh <= '{1'b1, dasrs_pkg::dasrs_src_type'(sc[i]), sr[i], 6'(sn[i])};
				acc_a <= sa[i];
				acc_b <= sa[i];
				bus <= 16'h8001;
			end else begin
				sh.valid <= 1'b0;
			end
			@(negedge clk);
			if (i > 0) begin
				e = es(sa[i-1], sc[i-1] == 2'h2, sr[i-1], sn[i-1]);
				chk("shift", e, sh_acc);
				chk("shift_word", {24'h1, e[31:16]}, {23'h0, sh_v, sh_word});
			end
		end
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("reset", 40'h0, {7'h0, xw});
		chk("reset_ptr", 40'h0, {7'h0, sh_v, ptr, sh_word});
		t_store();
		t_mac();
		t_refuse();
		t_shift();
		@(negedge clk);
		chk("writes", 40'hd, {8'h0, wr_cnt});
		wrap_up();
	end
endmodule // dasrs_bench
